// ===== hdl/dpc_decoder.sv
/*
  Digipot command decoder: 2-wire slave byte engine, instruction decode,
  wiper register, sixteen stored settings and a non-volatile write timer.
  Assumes SCL and SDA are slow open-drain pins sampled by clk_sys,
  and that rstn marks power-up.
*/
`timescale 1ns/1ps
`default_nettype none
module dpc_decoder
  import dpc_pkg::*;
#(
  parameter int NV_WRITE_CYC = DPC_NV_WRITE_CYC,
  parameter int LOAD_CYC     = DPC_LOAD_CYC
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  // 2-wire bus pins
  input  wire logic         scl_in,
  input  wire logic         sda_in,
  output logic              sda_out,
  output logic              sda_oe,
  // Straps
  input  wire logic [2:0]   slave_address_pins,
  input  wire logic         write_protect_n,
  // Potentiometer and status
  output logic      [255:0] tap_on,
  output logic      [7:0]   wiper_position,
  output logic              nv_busy
);

  // ---------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ---------------------------------------------------------------
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic       scl_d;
  logic       sda_d;
  logic [1:0] wp_sync;
  logic [2:0] adr_s1;
  logic [2:0] adr_s2;

  // Two flops each, plus a third on SCL and SDA for edge detection; stage one is never read by logic
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
      wp_sync  <= 2'h0;
      adr_s1   <= 3'h0;
      adr_s2   <= 3'h0;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      scl_d    <= scl_sync[1];
      sda_d    <= sda_sync[1];
      wp_sync  <= {wp_sync[0], write_protect_n};
      adr_s1   <= slave_address_pins;
      adr_s2   <= adr_s1;
    end
  end

  wire scl      = scl_sync[1];
  wire sda      = sda_sync[1];
  wire scl_rise = scl & ~scl_d;
  wire scl_fall = ~scl & scl_d;
  wire start_c  = scl & scl_d & sda_d & ~sda;
  wire stop_c   = scl & scl_d & ~sda_d & sda;
  wire wp_ok    = wp_sync[1];

  // ---------------------------------------------------------------
  // Byte engine state
  // ---------------------------------------------------------------
  typedef enum {
    ST_IDLE, ST_ID, ST_INSTR, ST_DATA_IN, ST_DATA_OUT, ST_STEP, ST_WAIT
  } dpc_state_type;

  dpc_state_type state;
  dpc_state_type next_state;
  logic [3:0]    bit_cnt;
  logic [7:0]    shift;
  logic [7:0]    instr;
  logic          ack_phase;
  logic          drive_low;
  logic          tx_bit;
  logic          master_nack;
  logic          ack_now_q;
  logic          nv_pend;
  logic [7:0]    nv_data;
  logic [3:0]    nv_index;

  // Stored settings; an array of sixteen bytes
  logic [7:0]    store [DPC_NUM_STORE];
  logic [7:0]    load_val;
  logic          load_pend;
  logic [31:0]   load_cnt;
  logic [31:0]   nv_cnt;

  // ---------------------------------------------------------------
  // Decode of the received bytes
  // ---------------------------------------------------------------
  wire [7:0] rx_byte   = {shift[6:0], sda};
  wire       type_ok   = rx_byte[DPC_TYPE_MSB:DPC_TYPE_LSB] == DPC_TYPE_CODE;
  wire       addr_ok   = rx_byte[DPC_ADDR_MSB+1:DPC_ADDR_LSB+1] == adr_s2;
  wire       is_read   = rx_byte[DPC_RW_BIT];
  wire [3:0] rx_op     = rx_byte[DPC_OP_MSB:DPC_OP_LSB];
  wire [3:0] op        = instr[DPC_OP_MSB:DPC_OP_LSB];
  wire [1:0] reg_sel   = instr[DPC_REG_MSB:DPC_REG_LSB];
  wire [1:0] bank_sel  = instr[DPC_BANK_MSB:DPC_BANK_LSB];
  wire [3:0] sel_index = {bank_sel, reg_sel};
  wire       rx_ptr0   = rx_byte[3:0] == 4'h0;
  wire       rx_bank0  = rx_byte[DPC_BANK_MSB:DPC_BANK_LSB] == 2'h0;

  // Validity of an instruction byte as received
  function automatic logic instr_valid(input logic [7:0] b);
    logic [3:0] o;
    o = b[DPC_OP_MSB:DPC_OP_LSB];
    case (o)
      DPC_OP_RD_WIPER, DPC_OP_WR_WIPER, DPC_OP_STEP:
        instr_valid = b[3:0] == 4'h0;
      DPC_OP_RD_STORE, DPC_OP_WR_STORE:
        instr_valid = 1'b1;
      DPC_OP_STO2WIP, DPC_OP_WIP2STO:
        instr_valid = b[1:0] == 2'h0;
      default:
        instr_valid = 1'b0;
    endcase
  endfunction : instr_valid

  // Which accepted instructions carry a data byte
  wire has_data_in  = op == DPC_OP_WR_WIPER || op == DPC_OP_WR_STORE;
  wire has_data_out = op == DPC_OP_RD_WIPER || op == DPC_OP_RD_STORE;
  wire [7:0] rd_val = (op == DPC_OP_RD_WIPER) ? wiper_position
                                              : store[sel_index];

  // Byte boundary: eighth bit sampled on this rising edge
  wire byte_done = scl_rise && bit_cnt == 4'h7 && !ack_phase;
  // Ack slot ends on the fall after the ninth clock, while we still pull low
  wire ack_done  = scl_fall && ack_phase && drive_low;

  // ---------------------------------------------------------------
  // Next-state decode
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE:     next_state = state;
      ST_ID:
        if (byte_done && !(type_ok && addr_ok && !nv_busy && !is_read))
          next_state = ST_WAIT;
        else if (ack_done)
          next_state = ST_INSTR;
      ST_INSTR:
        if (byte_done && !instr_valid(rx_byte))
          next_state = ST_WAIT;
        else if (ack_done && op == DPC_OP_STEP)
          next_state = ST_STEP;
        else if (ack_done && has_data_in)
          next_state = ST_DATA_IN;
        else if (ack_done && has_data_out)
          next_state = ST_DATA_OUT;
        else if (ack_done)
          next_state = ST_WAIT;
      ST_DATA_IN:  if (ack_done) next_state = ST_WAIT;
      ST_DATA_OUT: if (ack_done) next_state = ST_WAIT;
      ST_STEP:     next_state = state;
      ST_WAIT:     next_state = state;
      default:     next_state = ST_IDLE;
    endcase
    if (start_c)
      next_state = ST_ID;
    else if (stop_c)
      next_state = ST_IDLE;
  end

  // Acknowledge the byte just received in the ID, instruction or data-in phase
  // Step pulses and read data never earn an acknowledge from us
  wire ack_now = byte_done && next_state != ST_WAIT
                 && (state == ST_ID || state == ST_INSTR
                     || state == ST_DATA_IN);

  // ---------------------------------------------------------------
  // Bit counter, shifter and SDA drive
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state       <= ST_IDLE;
      bit_cnt     <= 4'h0;
      shift       <= 8'h00;
      instr       <= 8'h00;
      ack_phase   <= 1'b0;
      drive_low   <= 1'b0;
      tx_bit      <= 1'b1;
      master_nack <= 1'b0;
    end else begin
      state <= next_state;
      if (start_c || stop_c) begin
        bit_cnt   <= 4'h0;
        ack_phase <= 1'b0;
        drive_low <= 1'b0;
      end else if (scl_rise && !ack_phase) begin
        if (state != ST_DATA_OUT)
          shift <= rx_byte;                            // Keep transmit bits
        bit_cnt <= bit_cnt + 4'h1;
        if (state == ST_INSTR && bit_cnt == 4'h7)
          instr <= rx_byte;
        if (bit_cnt == 4'h7) begin
          ack_phase <= 1'b1;
          bit_cnt   <= 4'h0;
        end
      end else if (scl_rise && ack_phase) begin
        master_nack <= sda;
      end else if (scl_fall) begin
        if (ack_phase && !drive_low && state == ST_DATA_OUT) begin
          tx_bit <= 1'b1;                              // Free SDA for master
        end else if (ack_phase && drive_low) begin
          drive_low <= 1'b0;
          ack_phase <= 1'b0;
          if (next_state == ST_DATA_OUT) begin
            tx_bit  <= rd_val[7];
            shift   <= {rd_val[6:0], 1'b0};
          end
        end else if (state == ST_DATA_OUT && !ack_phase) begin
          tx_bit <= shift[7];
          shift  <= {shift[6:0], 1'b0};
        end else if (ack_now_q) begin
          drive_low <= 1'b1;
        end
      end
    end
  end

  // Remember that the last byte earned an acknowledge until SCL falls
  always_ff @(posedge clk_sys) begin
    if (!rstn || start_c || stop_c || scl_fall)
      ack_now_q <= 1'b0;
    else if (ack_now)
      ack_now_q <= 1'b1;
  end

  // Open drain: enable only when pulling low
  wire tx_low = state == ST_DATA_OUT && !ack_phase && !tx_bit;
  assign sda_out = 1'b0;
  assign sda_oe  = drive_low | tx_low;

  // ---------------------------------------------------------------
  // Command execution
  // ---------------------------------------------------------------
  wire data_rx    = byte_done && state == ST_DATA_IN;
  wire wr_store   = data_rx && op == DPC_OP_WR_STORE;
  wire xfer_rx    = byte_done && state == ST_INSTR && instr_valid(rx_byte);
  wire do_sto2wip = xfer_rx && rx_op == DPC_OP_STO2WIP && rx_bank0;
  wire do_wip2sto = xfer_rx && rx_op == DPC_OP_WIP2STO && rx_bank0;
  wire step_ev    = state == ST_STEP && scl_rise;
  wire nv_req     = (wr_store || do_wip2sto) && wp_ok;
  wire nv_launch  = nv_pend && stop_c;

  // Wiper register updates, power-up recall first
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      wiper_position <= DPC_STORE_RESET;
      load_pend      <= 1'b1;
      load_val       <= DPC_STORE_RESET;
      load_cnt       <= 32'h0;
    end else begin
      if (load_pend && load_cnt == 32'h0 && state == ST_IDLE
          && !do_sto2wip) begin
        load_val <= store[0];
      end
      if (do_sto2wip) begin
        load_val  <= store[{2'h0, rx_byte[DPC_REG_MSB:DPC_REG_LSB]}];
        load_pend <= 1'b1;
        load_cnt  <= LOAD_CYC[31:0];
      end else if (load_pend && load_cnt > 32'h1) begin
        load_cnt <= load_cnt - 32'h1;
      end else if (load_pend) begin
        wiper_position <= (load_cnt == 32'h0) ? store[0] : load_val;
        load_pend      <= 1'b0;
        load_cnt       <= 32'h0;
      end
      if (data_rx && op == DPC_OP_WR_WIPER)
        wiper_position <= rx_byte;
      else if (step_ev && sda && wiper_position != 8'hff)
        wiper_position <= wiper_position + 8'h01;
      else if (step_ev && !sda && wiper_position != 8'h00)
        wiper_position <= wiper_position - 8'h01;
    end
  end

  // Non-volatile write: latch on command, start at stop, time it out
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      nv_pend  <= 1'b0;
      nv_busy  <= 1'b0;
      nv_cnt   <= 32'h0;
      nv_data  <= 8'h00;
      nv_index <= 4'h0;
    end else begin
      if (nv_req) begin
        nv_pend  <= 1'b1;
        nv_data  <= wr_store ? rx_byte : wiper_position;
        nv_index <= wr_store ? sel_index
                    : {2'h0, rx_byte[DPC_REG_MSB:DPC_REG_LSB]};
      end else if (start_c) begin
        nv_pend <= 1'b0;
      end
      if (nv_launch) begin
        nv_pend <= 1'b0;
        nv_busy <= 1'b1;
        nv_cnt  <= NV_WRITE_CYC[31:0];
      end else if (nv_busy && nv_cnt > 32'h1) begin
        nv_cnt <= nv_cnt - 32'h1;
      end else if (nv_busy) begin
        nv_busy <= 1'b0;
        nv_cnt  <= 32'h0;
      end
    end
  end

  // Storage array commits when the write cycle ends
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      for (int i = 0; i < DPC_NUM_STORE; i++)
        store[i] <= DPC_STORE_RESET;
    end else if (nv_busy && nv_cnt == 32'h1) begin
      store[nv_index] <= nv_data;
    end
  end

  // ---------------------------------------------------------------
  // Tap switch decoder
  // ---------------------------------------------------------------
  dpc_tap_decode #(
    .TAPS     (256)
  ) u_tap (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .position (wiper_position),
    .tap_on   (tap_on)
  );

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_busy_no_ack: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state == ST_ID && byte_done && nv_busy) |=> !ack_now_q)
    else $error("address acknowledged during write");

  chk_wp_blocks: assert property (@(posedge clk_sys) disable iff (!rstn)
    (wr_store && !wp_ok && !nv_pend) |=> !nv_pend)
    else $error("write queued while protected");

  chk_nv_length: assert property (@(posedge clk_sys) disable iff (!rstn)
    nv_launch |=> nv_busy && nv_cnt == NV_WRITE_CYC[31:0])
    else $error("write timer not loaded");

  chk_step_sat: assert property (@(posedge clk_sys) disable iff (!rstn)
    (step_ev && sda && wiper_position == 8'hff && !load_pend)
    |=> wiper_position == 8'hff)
    else $error("wiper wrapped at top");

  chk_step_up: assert property (@(posedge clk_sys) disable iff (!rstn)
    (step_ev && sda && wiper_position != 8'hff && !load_pend)
    |=> wiper_position == $past(wiper_position) + 8'h01)
    else $error("wiper did not step up");

  chk_wr_wiper: assert property (@(posedge clk_sys) disable iff (!rstn)
    (data_rx && op == DPC_OP_WR_WIPER) |=> wiper_position == $past(rx_byte))
    else $error("wiper write lost");

  chk_bad_type: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state == ST_ID && byte_done && !type_ok && !start_c && !stop_c)
    |=> state == ST_WAIT)
    else $error("foreign type code not ignored");

  chk_bank_xfer: assert property (@(posedge clk_sys) disable iff (!rstn)
    (byte_done && state == ST_INSTR && rx_op == DPC_OP_STO2WIP
     && !rx_bank0 && !load_pend) |=> !load_pend)
    else $error("transfer outside bank 0");

endmodule : dpc_decoder
`default_nettype wire

// ===== hdl/dpc_pkg.sv
/*
  Shared constants for the digipot command decoder: byte fields, opcodes,
  device type code and timing counts.
  Assumes a 25 MHz system clock.
*/
package dpc_pkg;

  // ---------------------------------------------------------------
  // Identification byte
  // ---------------------------------------------------------------
  // Device type code; the value is arbitrary.
  localparam logic [3:0] DPC_TYPE_CODE = 4'h6;
  localparam int         DPC_TYPE_MSB  = 7;
  localparam int         DPC_TYPE_LSB  = 4;
  localparam int         DPC_ADDR_MSB  = 2;
  localparam int         DPC_ADDR_LSB  = 0;
  localparam int         DPC_RW_BIT    = 0;

  // ---------------------------------------------------------------
  // Instruction byte
  // ---------------------------------------------------------------
  localparam int         DPC_OP_MSB    = 7;
  localparam int         DPC_OP_LSB    = 4;
  localparam int         DPC_REG_MSB   = 3;
  localparam int         DPC_REG_LSB   = 2;
  localparam int         DPC_BANK_MSB  = 1;
  localparam int         DPC_BANK_LSB  = 0;

  localparam logic [3:0] DPC_OP_RD_WIPER = 4'h9;
  localparam logic [3:0] DPC_OP_WR_WIPER = 4'ha;
  localparam logic [3:0] DPC_OP_RD_STORE = 4'hb;
  localparam logic [3:0] DPC_OP_WR_STORE = 4'hc;
  localparam logic [3:0] DPC_OP_STO2WIP  = 4'hd;
  localparam logic [3:0] DPC_OP_WIP2STO  = 4'he;
  localparam logic [3:0] DPC_OP_STEP     = 4'h2;

  // ---------------------------------------------------------------
  // Storage and timing
  // ---------------------------------------------------------------
  localparam int         DPC_NUM_STORE   = 16;
  localparam logic [7:0] DPC_STORE_RESET = 8'h80;
  localparam int         DPC_CLK_HZ      = 25000000;
  localparam int         DPC_NV_WRITE_MS = 10;
  localparam int         DPC_NV_WRITE_CYC =
    DPC_CLK_HZ / 1000 * DPC_NV_WRITE_MS;
  localparam int         DPC_LOAD_NS     = 200;
  localparam int         DPC_LOAD_CYC    =
    (DPC_LOAD_NS * (DPC_CLK_HZ / 1000000) + 999) / 1000;

endpackage : dpc_pkg

// ===== hdl/dpc_tap_decode.sv
/*
  One-hot decoder from the wiper position to the 256 tap switches.
  Assumes a registered position input on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module dpc_tap_decode #(
  parameter int TAPS = 256
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  // Position in, switches out
  input  wire logic [7:0]        position,
  output logic      [TAPS-1:0]   tap_on
);

  // Registered one-hot so exactly one switch closes per cycle out of reset; reset opens all switches
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      tap_on <= '0;
    end else begin
      tap_on <= {{(TAPS-1){1'b0}}, 1'b1} << position;
    end
  end

  chk_tap_onehot: assert property (@(posedge clk_sys) disable iff (!rstn)
    $past(rstn) |-> $onehot(tap_on))
    else $error("tap switches not one-hot");

endmodule : dpc_tap_decode
`default_nettype wire

// ===== dv/dpc_bus_master.sv
/*
  Behavioural 2-wire bus master driving the digipot decoder.
  Assumes the bench resolves open-drain SDA with a pull-up.
*/
`timescale 1ns/1ps
`default_nettype none
module dpc_bus_master (
  // Pacing clock
  input  wire logic clk_sys,
  // Bus pins
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);
  // ---------------------------------------------------------------
  // Bit and byte phases
  // ---------------------------------------------------------------
  // SCL stands high between frames; quarter of 80 ns gives 320 ns bits
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  task automatic quarter();
    repeat (2) @(negedge clk_sys);
  endtask : quarter

  // SDA falls while SCL is high to open a frame
  task automatic start();
    scl = 1'b1;
    quarter();
    sda_low = 1'b1;
    quarter();
    scl = 1'b0;
    quarter();
  endtask : start

  // SDA moves only while SCL is low, so no false start or stop
  task automatic bit_out(input logic b);
    sda_low = !b;
    quarter();
    scl = 1'b1;
    quarter();
    quarter();
    scl = 1'b0;
    quarter();
  endtask : bit_out

  // Released SDA reads the pull-up unless the device drives it
  task automatic bit_in(output logic b);
    sda_low = 1'b0;
    quarter();
    scl = 1'b1;
    quarter();
    b = sda_line;
    quarter();
    scl = 1'b0;
    quarter();
  endtask : bit_in

  // Most significant bit first, ninth clock samples the acknowledge
  task automatic byte_out(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_in(b);
    ack = !b;
  endtask : byte_out

  // Master ends a read with no acknowledge
  task automatic byte_in(output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_in(d[i]);
    bit_out(1'b1);
  endtask : byte_in

  // SDA rises while SCL is high to close the frame
  task automatic stop();
    sda_low = 1'b1;
    quarter();
    scl = 1'b1;
    quarter();
    sda_low = 1'b0;
    quarter();
  endtask : stop
endmodule : dpc_bus_master
`default_nettype wire

// ===== dv/dpc_decoder_test.sv
/*
  Self-checking bench for the digipot command decoder.
  Assumes the bus master model and a shortened write time.
*/
`timescale 1ns/1ps
`default_nettype none
module dpc_decoder_test
  import dpc_pkg::*;
;
  // ---------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------
  localparam int NV_CYC = 200;
  logic         clk_sys, rstn, scl, sda_low, sda_line, sda_out, sda_oe;
  logic         write_protect_n, nv_busy;
  logic [2:0]   slave_address_pins, acks;
  logic [255:0] tap_on;
  logic [7:0]   wiper_position, rd, v;
  logic [7:0]   shadow [16];
  logic [3:0]   k;
  int           fails, samples_checked, seed;

  // Open-drain wire with pull-up
  assign sda_line = !(sda_low || (sda_oe && !sda_out));

  dpc_decoder #(.NV_WRITE_CYC(NV_CYC), .LOAD_CYC(DPC_LOAD_CYC))
    i_dpc_decoder (.clk_sys(clk_sys), .rstn(rstn), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .slave_address_pins(slave_address_pins),
    .write_protect_n(write_protect_n), .tap_on(tap_on),
    .wiper_position(wiper_position), .nv_busy(nv_busy));

  dpc_bus_master i_dpc_bus_master (.clk_sys(clk_sys),
    .sda_line(sda_line), .scl(scl), .sda_low(sda_low));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [255:0] seen, input logic [255:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("checked %0d, wrong %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test

  function automatic logic [7:0] idb();
    return {DPC_TYPE_CODE, slave_address_pins, 1'b0};
  endfunction : idb

  function automatic logic [255:0] tap_exp(input logic [7:0] w);
    return 256'(1) << w;
  endfunction : tap_exp

  // Mode 0 two bytes, 1 write data, 2 read data
  task automatic xfer(input logic [7:0] id, input logic [7:0] instr,
      input int mode, input logic [7:0] wd, output logic [7:0] r,
      output logic [2:0] ak);
    ak = 3'b000;
    r = 8'h00;
    i_dpc_bus_master.start();
    i_dpc_bus_master.byte_out(id, ak[2]);
    if (ak[2]) i_dpc_bus_master.byte_out(instr, ak[1]);
    if (ak[1] && mode == 1) i_dpc_bus_master.byte_out(wd, ak[0]);
    if (ak[1] && mode == 2) i_dpc_bus_master.byte_in(r);
    i_dpc_bus_master.stop();
    repeat (8) @(negedge clk_sys);
  endtask : xfer

  // Poll while busy, then wait out the write under a bound
  task automatic wait_nv();
    logic [7:0] r;
    logic [2:0] a;
    check(256'(nv_busy), 256'(1'b1));
    xfer(idb(), 8'h00, 0, 8'h00, r, a);
    check(256'(a), 256'(3'b000));
    for (int n = 0; n < NV_CYC && nv_busy === 1'b1; n++)
      @(negedge clk_sys);
    check(256'(nv_busy), 256'(1'b0));
  endtask : wait_nv

  // Wiper is checked before stop so the stop's SCL pulse cannot blur it
  task automatic step(input logic [7:0] from, input logic up, input int n);
    logic [7:0] r, e;
    logic [2:0] a;
    xfer(idb(), {DPC_OP_WR_WIPER, 4'h0}, 1, from, r, a);
    e = from;
    i_dpc_bus_master.start();
    i_dpc_bus_master.byte_out(idb(), a[2]);
    i_dpc_bus_master.byte_out({DPC_OP_STEP, 4'h0}, a[1]);
    repeat (n) begin
      i_dpc_bus_master.bit_out(up);
      if (up && e != 8'hff) e++;
      else if (!up && e != 8'h00) e--;
    end
    repeat (4) @(negedge clk_sys);
    check(256'(wiper_position), 256'(e));
    i_dpc_bus_master.stop();
  endtask : step

  // ---------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ---------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Full run needs about 20000 cycles
  initial begin
    repeat (80000) @(posedge clk_sys);
    fails++;
    end_of_test();
  end

  initial begin
    seed = 32'ha35d;
    fails = 0;
    samples_checked = 0;
    rstn = 1'b0;
    write_protect_n = 1'b1;
    slave_address_pins = 3'($random(seed));
    repeat (12) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (12) @(negedge clk_sys);
    check(256'(wiper_position), 256'(DPC_STORE_RESET));
    check(tap_on, tap_exp(DPC_STORE_RESET));
    for (int i = 0; i < 16; i++) shadow[i] = DPC_STORE_RESET;
    $display("test power_up done");
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
      xfer(idb(), {DPC_OP_WR_WIPER, 4'h0}, 1, v, rd, acks);
      check(256'(acks), 256'(3'b111));
      check(256'(wiper_position), 256'(v));
      check(tap_on, tap_exp(v));
      xfer(idb(), {DPC_OP_RD_WIPER, 4'h0}, 2, 8'h00, rd, acks);
      check(256'(rd), 256'(v));
    end
    $display("test wiper_access done");
    for (int i = 0; i < 16; i++) begin
      k = 4'(i);
      v = 8'($random(seed));
      shadow[i] = v;
      xfer(idb(), {DPC_OP_WR_STORE, k[1:0], k[3:2]}, 1, v, rd, acks);
      check(256'(acks), 256'(3'b111));
      wait_nv();
    end
    for (int i = 0; i < 16; i++) begin
      k = 4'(i);
      xfer(idb(), {DPC_OP_RD_STORE, k[1:0], k[3:2]}, 2, 8'h00, rd, acks);
      check(256'(rd), 256'(shadow[i]));
    end
    $display("test stored_settings done");
    for (int i = 0; i < 4; i++) begin
      k = 4'(i);
      xfer(idb(), {DPC_OP_STO2WIP, k[1:0], 2'b00}, 0, 8'h00, rd, acks);
      check(256'(acks), 256'(3'b110));
      check(256'(wiper_position), 256'(shadow[i]));
      xfer(idb(), {DPC_OP_STO2WIP, k[1:0], 2'b01}, 0, 8'h00, rd, acks);
      check(256'(acks), 256'(3'b100));
      check(256'(wiper_position), 256'(shadow[i]));
      v = 8'($random(seed));
      xfer(idb(), {DPC_OP_WR_WIPER, 4'h0}, 1, v, rd, acks);
      xfer(idb(), {DPC_OP_WIP2STO, k[1:0], 2'b00}, 0, 8'h00, rd, acks);
      wait_nv();
      shadow[i] = v;
      xfer(idb(), {DPC_OP_RD_STORE, k[1:0], 2'b00}, 2, 8'h00, rd, acks);
      check(256'(rd), 256'(v));
    end
    $display("test transfers done");
    write_protect_n = 1'b0;
    xfer(idb(), {DPC_OP_WR_STORE, 4'h9}, 1, ~shadow[6], rd, acks);
    check(256'(acks), 256'(3'b111));
    check(256'(nv_busy), 256'(1'b0));
    xfer(idb(), {DPC_OP_RD_STORE, 4'h9}, 2, 8'h00, rd, acks);
    check(256'(rd), 256'(shadow[6]));
    write_protect_n = 1'b1;
    xfer(idb() ^ 8'h10, {DPC_OP_RD_WIPER, 4'h0}, 2, 8'h00, rd, acks);
    check(256'(acks), 256'(3'b000));
    xfer(idb() ^ 8'h04, {DPC_OP_RD_WIPER, 4'h0}, 2, 8'h00, rd, acks);
    check(256'(acks), 256'(3'b000));
    $display("test refusals done");
    step(8'hfd, 1'b1, 4);
    step(8'h02, 1'b0, 4);
    step(8'($random(seed)) | 8'h10, 1'b0, 3);
    step(8'($random(seed)) & 8'h7f, 1'b1, 5);
    $display("test stepping done");
    end_of_test();
  end
endmodule : dpc_decoder_test
`default_nettype wire
